//--- common/sptw_pkg.sv
// constants shared by the segment/page table walker and its translation caches
// assumes 32-bit virtual and physical addresses and word-wide table entries
package sptw_pkg;
  // address split
  localparam int VA_W        = 32;
  localparam int VPN_W       = 20;
  localparam int SEG_W       = 10;
  localparam int SEG_LO      = 22;
  localparam int PG_LO       = 12;
  localparam int ROOT_LO     = 12;
  // table entry field positions
  localparam int B_V         = 0;
  localparam int B_W         = 1;
  localparam int B_U         = 2;
  localparam int B_K         = 3;
  localparam int B_R         = 3;
  localparam int B_M         = 4;
  localparam int B_C         = 11;
  // packed layout of a lookaside buffer entry: {pfn, c, u, w, m}
  localparam int TD_W        = 24;
  localparam int TD_M        = 0;
  localparam int TD_WR       = 1;
  localparam int TD_U        = 2;
  localparam int TD_C        = 3;
  localparam int TD_PFN      = 4;
  // packed layout of a flat region entry: {base, bound, c, u, w}
  localparam int FD_W        = 23;
  localparam int FD_WR       = 0;
  localparam int FD_U        = 1;
  localparam int FD_C        = 2;
  localparam int FD_BND      = 3;
  localparam int FD_BASE     = 13;
  // sizes and timing
  localparam int TLB_ENTRIES_DEF  = 32;
  localparam int MICRO_UPDATE_CYC = 1;

  typedef enum logic [2:0] {FLT_NONE, FLT_FETCH, FLT_READ, FLT_WRITE, FLT_BUS} sptw_fault_e;
endpackage

//--- logic/sptw_tlb.sv
// fully associative translation lookaside buffer, round-robin replacement
// assumes fills, drops and flushes come from the walker on the same clock
`timescale 1ns/1ps
`default_nettype none
module sptw_tlb #(
  parameter int ENTRIES = sptw_pkg::TLB_ENTRIES_DEF,
  parameter int DW      = sptw_pkg::TD_W
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     flushAll,
  input  wire logic                     dropValid,
  input  wire logic [sptw_pkg::VPN_W-1:0] dropVpn,
  input  wire logic [sptw_pkg::VPN_W-1:0] lookVpn,
  output logic                          hit,
  output logic [DW-1:0]                 hitData,
  input  wire logic                     fillValid,
  input  wire logic [sptw_pkg::VPN_W-1:0] fillVpn,
  input  wire logic [DW-1:0]            fillData
);
  localparam int PW = $clog2(ENTRIES);

  if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0) begin : g_chk
    $error("sptw_tlb: ENTRIES must be a power of two");
  end

  logic [ENTRIES-1:0]         valid_q;
  logic [ENTRIES-1:0]         match;
  logic [sptw_pkg::VPN_W-1:0] tag_q  [ENTRIES];
  logic [DW-1:0]              data_q [ENTRIES];
  logic [PW-1:0]              ptr_q;

  // per entry: a fill also kills an older copy of the same page, no duplicates
  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    assign match[i] = valid_q[i] && (tag_q[i] == lookVpn);
    always_ff @(posedge clk) begin
      if (!resetn || flushAll) begin
        valid_q[i] <= 1'b0;
      end else if (fillValid && ptr_q == PW'(i)) begin
        valid_q[i] <= 1'b1;
        tag_q[i]   <= fillVpn;
        data_q[i]  <= fillData;
      end else if ((dropValid && tag_q[i] == dropVpn) || (fillValid && tag_q[i] == fillVpn)) begin
        valid_q[i] <= 1'b0;
      end
    end
  end

  // replacement pointer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ptr_q <= '0;
    end else if (fillValid) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // one-hot match, so an or-reduction selects the data
  always_comb begin
    hitData = '0;
    for (int k = 0; k < ENTRIES; k++) begin
      if (match[k]) begin
        hitData = hitData | data_q[k];
      end
    end
  end
  assign hit = |match;
endmodule // sptw_tlb
`default_nettype wire

//--- logic/sptw_flat_cache.sv
// single-entry cache of the last nonpaged segment entry used
// assumes fills, drops and flushes come from the walker on the same clock
`timescale 1ns/1ps
`default_nettype none
module sptw_flat_cache (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       flushAll,
  input  wire logic                       dropValid,
  input  wire logic [sptw_pkg::SEG_W-1:0] dropSeg,
  input  wire logic [sptw_pkg::SEG_W-1:0] lookSeg,
  output logic                            hit,
  output logic [sptw_pkg::FD_W-1:0]       hitData,
  input  wire logic                       fillValid,
  input  wire logic [sptw_pkg::SEG_W-1:0] fillSeg,
  input  wire logic [sptw_pkg::FD_W-1:0]  fillData
);
  logic                       valid_q;
  logic [sptw_pkg::SEG_W-1:0] seg_q;
  logic [sptw_pkg::FD_W-1:0]  data_q;

  // fill wins over a drop of another segment in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn || flushAll) begin
      valid_q <= 1'b0;
    end else if (fillValid) begin
      valid_q <= 1'b1;
      seg_q   <= fillSeg;
      data_q  <= fillData;
    end else if (dropValid && dropSeg == seg_q) begin
      valid_q <= 1'b0;
    end
  end

  assign hit     = valid_q && (seg_q == lookSeg);
  assign hitData = data_q;
endmodule // sptw_flat_cache
`default_nettype wire

//--- logic/sptw_walker.sv
// segment/page table walker with text and data translation caches
// assumes one request at a time from the core and a word bus that acks every access
// Function
// R1 - segment entry address is root bits 31:12 joined with virtual bits 31:22
// R2 - entry bit 3 picks paged (0) or nonpaged (1); kinds may mix
// R3 - paged segment bits 31:12 are page table base; bit 11 sets fetch caching
// R4 - an entry maps only when its valid bit 0 is set
// R5 - nonpaged entry: base in bits 31:22, size bound in 21:12 per 4 KB
// R6 - nonpaged physical address is segment base then the segment offset
// R7 - cache bit 0 asserts the uncached indicator for that region
// R8 - user access needs bit 2, writes need bit 1; kernel reads always
// R9 - page entry address is segment entry bits 31:12 joined with page number
// R10 - paged physical address is page frame base then the 12-bit offset
// R11 - protection violation gives a fault and no memory access
// R12 - first write sets modified bit 4 in memory, later writes skip it
// R13 - first reference sets referenced bit 3 in memory, only once
// R14 - software clears referenced and modified bits and then drops the entry
// R15 - every reset empties both lookaside buffers and both flat caches
// R16 - writing the table root pointer empties all translation caches
// R17 - drop operation invalidates cached translations of its address
// R18 - drop operation needs no privilege and never faults
// R19 - lock held over page entry fetch and its write-back, else released
// R20 - bus error during the walk abandons it with an exception
// R21 - translate only when the state word bit is set; 32-entry buffers
// R22 - fault kind follows access: fetch, read, or write for stores
// R23 - micro cache miss that hits a text cache costs exactly one cycle
// R24 - nonpaged page index above the bound is a missing mapping
// R25 - segment entry read first; caches filled only after a clean walk
`timescale 1ns/1ps
`default_nettype none
module sptw_walker #(
  parameter int TLB_ENTRIES = sptw_pkg::TLB_ENTRIES_DEF
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        translateOn,
  input  wire logic [31:0] tableRootPointer,
  input  wire logic        rootWrite,
  input  wire logic        dropTranslationOp,
  input  wire logic [31:0] dropAddr,
  input  wire logic        reqValid,
  input  wire logic [31:0] reqAddr,
  input  wire logic        reqText,
  input  wire logic        reqWrite,
  input  wire logic        reqUser,
  output logic             reqReady,
  output logic             rspValid,
  output logic [31:0]      rspAddr,
  output logic             rspUncachedAccessN,
  output logic             rspFault,
  output sptw_pkg::sptw_fault_e rspFaultKind,
  output logic             memReq,
  output logic [31:0]      memAddr,
  output logic             memWrite,
  output logic [31:0]      memWdata,
  output logic             memLock,
  output logic             memUncachedAccessN,
  input  wire logic        memAck,
  input  wire logic        memErr,
  input  wire logic [31:0] memRdata
);
  typedef enum {ST_IDLE, ST_LOOK, ST_SEG, ST_PTE, ST_WB} sptw_state_e;

  sptw_state_e           state_q;
  logic [31:0]           root_q, va_q, memAddr_q, memWdata_q, rspAddr_q;
  logic                  text_q, write_q, user_q, reqReady_q;
  logic                  rspValid_q, rspUncN_q, rspFault_q;
  sptw_pkg::sptw_fault_e rspKind_q;
  logic                  memReq_q, memWrite_q, memLock_q, memUncN_q;
  logic                  microValid_q, microC_q, microU_q;
  logic [19:0]           microVpn_q, microPfn_q;
  logic                  fillTlb_q, fillFlat_q;
  logic [sptw_pkg::TD_W-1:0] fillTlbData_q, tDataT, tDataD, tData;
  logic [sptw_pkg::FD_W-1:0] fillFlatData_q, fDataT, fDataD, fData;
  logic                  tHitT, tHitD, fHitT, fHitD, tHit, fHit, tlbUse, flushAll;
  logic                  microHit, fOob, sOob, eV, eW, eU, eK, eR, eM, eC;
  logic [9:0]            fBound;
  sptw_pkg::sptw_fault_e kindF;
  logic [31:0]           pteNew;

  assign flushAll = rootWrite; // R16
  assign tHit     = text_q ? tHitT : tHitD;
  assign tData    = text_q ? tDataT : tDataD;
  assign fHit     = text_q ? fHitT : fHitD;
  assign fData    = text_q ? fDataT : fDataD;
  // a clean write hit still walks while the cached copy lacks the modified bit
  assign tlbUse   = tHit && !(write_q && !tData[sptw_pkg::TD_M]); // R12
  assign fBound   = fData[sptw_pkg::FD_BND +: 10];
  assign fOob     = va_q[21:12] > fBound; // R24
  assign kindF    = write_q ? sptw_pkg::FLT_WRITE :
                    (text_q ? sptw_pkg::FLT_FETCH : sptw_pkg::FLT_READ); // R22
  assign microHit = reqText && microValid_q && reqAddr[31:12] == microVpn_q &&
                    (!reqUser || microU_q);
  // fields of the entry arriving from memory
  assign eV     = memRdata[sptw_pkg::B_V]; // R4
  assign eW     = memRdata[sptw_pkg::B_W];
  assign eU     = memRdata[sptw_pkg::B_U];
  assign eK     = memRdata[sptw_pkg::B_K]; // R2
  assign eR     = memRdata[sptw_pkg::B_R];
  assign eM     = memRdata[sptw_pkg::B_M];
  assign eC     = memRdata[sptw_pkg::B_C];
  assign sOob   = va_q[21:12] > memRdata[21:12]; // R5
  assign pteNew = {memRdata[31:5], eM | write_q, 1'b1, memRdata[2:0]}; // R13

  // kernel may always read a valid mapping; writes always need the write bit
  function automatic logic deny(input logic u, input logic w);
    return (user_q && !u) || (write_q && !w); // R8
  endfunction

  // finish a request; rsp fields stand until the next response
  task automatic respond(input logic [31:0] a, input logic c, input sptw_pkg::sptw_fault_e k,
                         input logic upd, input logic u);
    rspValid_q <= 1'b1;
    rspAddr_q  <= a;
    rspUncN_q  <= c; // R7
    rspFault_q <= (k != sptw_pkg::FLT_NONE);
    rspKind_q  <= k;
    reqReady_q <= 1'b1;
    state_q    <= ST_IDLE;
    if (upd && text_q && k == sptw_pkg::FLT_NONE) begin
      microValid_q <= 1'b1;
      microVpn_q   <= va_q[31:12];
      microPfn_q   <= a[31:12];
      microC_q     <= c;
      microU_q     <= u;
    end
  endtask

  // clean page walk end: answer, then fill the buffer
  task automatic pteDone(input logic [31:0] e);
    respond({e[31:12], va_q[11:0]}, e[sptw_pkg::B_C], sptw_pkg::FLT_NONE, 1'b1,
            e[sptw_pkg::B_U]); // R10
    fillTlb_q     <= 1'b1; // R25
    fillTlbData_q <= {e[31:12], e[sptw_pkg::B_C], e[sptw_pkg::B_U], e[sptw_pkg::B_W],
                      e[sptw_pkg::B_M]};
  endtask

  // root pointer, captured on software write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      root_q <= 32'h0000_0000;
    end else if (rootWrite) begin
      root_q <= tableRootPointer;
    end
  end

  // request, walk and bus sequencing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q        <= ST_IDLE;
      reqReady_q     <= 1'b1;
      va_q           <= 32'h0000_0000;
      text_q         <= 1'b0;
      write_q        <= 1'b0;
      user_q         <= 1'b0;
      rspValid_q     <= 1'b0;
      rspAddr_q      <= 32'h0000_0000;
      rspUncN_q      <= 1'b1;
      rspFault_q     <= 1'b0;
      rspKind_q      <= sptw_pkg::FLT_NONE;
      memReq_q       <= 1'b0;
      memAddr_q      <= 32'h0000_0000;
      memWrite_q     <= 1'b0;
      memWdata_q     <= 32'h0000_0000;
      memLock_q      <= 1'b0;
      memUncN_q      <= 1'b1;
      microValid_q   <= 1'b0; // R15
      microVpn_q     <= 20'h00000;
      microPfn_q     <= 20'h00000;
      microC_q       <= 1'b1;
      microU_q       <= 1'b0;
      fillTlb_q      <= 1'b0;
      fillFlat_q     <= 1'b0;
      fillTlbData_q  <= '0;
      fillFlatData_q <= '0;
    end else begin
      rspValid_q <= 1'b0;
      fillTlb_q  <= 1'b0;
      fillFlat_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (reqValid && reqReady_q) begin
            va_q       <= reqAddr;
            text_q     <= reqText;
            write_q    <= reqWrite;
            user_q     <= reqUser;
            reqReady_q <= 1'b0;
            if (!translateOn) begin
              respond(reqAddr, 1'b1, sptw_pkg::FLT_NONE, 1'b0, 1'b0); // R21
            end else if (microHit) begin
              respond({microPfn_q, reqAddr[11:0]}, microC_q, sptw_pkg::FLT_NONE, 1'b0, 1'b0);
            end else begin
              state_q <= ST_LOOK; // R23
            end
          end
        end
        ST_LOOK: begin
          if (fHit) begin
            if (fOob || deny(fData[sptw_pkg::FD_U], fData[sptw_pkg::FD_WR])) begin
              respond(va_q, 1'b1, kindF, 1'b0, 1'b0); // R11
            end else begin
              respond({fData[sptw_pkg::FD_BASE +: 10], va_q[21:0]}, fData[sptw_pkg::FD_C],
                      sptw_pkg::FLT_NONE, 1'b1, fData[sptw_pkg::FD_U]); // R6
            end
          end else if (tlbUse) begin
            if (deny(tData[sptw_pkg::TD_U], tData[sptw_pkg::TD_WR])) begin
              respond(va_q, 1'b1, kindF, 1'b0, 1'b0); // R11
            end else begin
              respond({tData[sptw_pkg::TD_PFN +: 20], va_q[11:0]}, tData[sptw_pkg::TD_C],
                      sptw_pkg::FLT_NONE, 1'b1, tData[sptw_pkg::TD_U]); // R23
            end
          end else begin
            memReq_q   <= 1'b1;
            memAddr_q  <= {root_q[31:sptw_pkg::ROOT_LO], va_q[31:sptw_pkg::SEG_LO], 2'b00}; // R1
            memWrite_q <= 1'b0;
            memLock_q  <= 1'b0;
            memUncN_q  <= 1'b1;
            state_q    <= ST_SEG; // R25
          end
        end
        ST_SEG: begin
          if (memAck) begin
            memReq_q <= 1'b0;
            if (memErr) begin
              respond(va_q, 1'b1, sptw_pkg::FLT_BUS, 1'b0, 1'b0); // R20
            end else if (!eV) begin
              respond(va_q, 1'b1, kindF, 1'b0, 1'b0); // R4
            end else if (eK) begin
              if (sOob || deny(eU, eW)) begin
                respond(va_q, 1'b1, kindF, 1'b0, 1'b0); // R24
              end else begin
                respond({memRdata[31:22], va_q[21:0]}, eC, sptw_pkg::FLT_NONE, 1'b1, eU); // R6
                fillFlat_q     <= 1'b1; // R25
                fillFlatData_q <= {memRdata[31:12], eC, eU, eW}; // R5
              end
            end else begin
              memReq_q  <= 1'b1;
              memAddr_q <= {memRdata[31:12], va_q[21:12], 2'b00}; // R9
              memLock_q <= 1'b1; // R19
              memUncN_q <= eC; // R3
              state_q   <= ST_PTE;
            end
          end
        end
        ST_PTE: begin
          if (memAck) begin
            memReq_q <= 1'b0;
            if (memErr || !eV || deny(eU, eW)) begin
              memLock_q <= 1'b0; // R19
              respond(va_q, 1'b1, memErr ? sptw_pkg::FLT_BUS : kindF, 1'b0, 1'b0); // R20
            end else if (!eR || (write_q && !eM)) begin
              memReq_q   <= 1'b1; // R12
              memWrite_q <= 1'b1;
              memWdata_q <= pteNew;
              state_q    <= ST_WB;
            end else begin
              memLock_q <= 1'b0; // R19
              pteDone(memRdata);
            end
          end
        end
        ST_WB: begin
          if (memAck) begin
            memReq_q   <= 1'b0;
            memWrite_q <= 1'b0;
            memLock_q  <= 1'b0; // R19
            if (memErr) begin
              respond(va_q, 1'b1, sptw_pkg::FLT_BUS, 1'b0, 1'b0); // R20
            end else begin
              pteDone(memWdata_q);
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      // any drop may hit the micro entry; clearing it costs only one refill
      if (rootWrite || dropTranslationOp) begin
        microValid_q <= 1'b0; // R17
      end
    end
  end

  // text and data translation caches; drops take no privilege check
  sptw_tlb #(.ENTRIES(TLB_ENTRIES), .DW(sptw_pkg::TD_W)) u_tlb_text (
    .clk(clk), .resetn(resetn), .flushAll(flushAll),
    .dropValid(dropTranslationOp), .dropVpn(dropAddr[31:12]), // R18
    .lookVpn(va_q[31:12]), .hit(tHitT), .hitData(tDataT),
    .fillValid(fillTlb_q && text_q), .fillVpn(va_q[31:12]), .fillData(fillTlbData_q)
  );
  sptw_tlb #(.ENTRIES(TLB_ENTRIES), .DW(sptw_pkg::TD_W)) u_tlb_data (
    .clk(clk), .resetn(resetn), .flushAll(flushAll),
    .dropValid(dropTranslationOp), .dropVpn(dropAddr[31:12]), // R17
    .lookVpn(va_q[31:12]), .hit(tHitD), .hitData(tDataD),
    .fillValid(fillTlb_q && !text_q), .fillVpn(va_q[31:12]), .fillData(fillTlbData_q)
  );
  sptw_flat_cache u_flat_text (
    .clk(clk), .resetn(resetn), .flushAll(flushAll),
    .dropValid(dropTranslationOp), .dropSeg(dropAddr[31:22]),
    .lookSeg(va_q[31:22]), .hit(fHitT), .hitData(fDataT),
    .fillValid(fillFlat_q && text_q), .fillSeg(va_q[31:22]), .fillData(fillFlatData_q)
  );
  sptw_flat_cache u_flat_data (
    .clk(clk), .resetn(resetn), .flushAll(flushAll),
    .dropValid(dropTranslationOp), .dropSeg(dropAddr[31:22]),
    .lookSeg(va_q[31:22]), .hit(fHitD), .hitData(fDataD),
    .fillValid(fillFlat_q && !text_q), .fillSeg(va_q[31:22]), .fillData(fillFlatData_q)
  );

  // outputs straight from flops
  assign reqReady           = reqReady_q;
  assign rspValid           = rspValid_q;
  assign rspAddr            = rspAddr_q;
  assign rspUncachedAccessN = rspUncN_q;
  assign rspFault           = rspFault_q;
  assign rspFaultKind       = rspKind_q;
  assign memReq             = memReq_q;
  assign memAddr            = memAddr_q;
  assign memWrite           = memWrite_q;
  assign memWdata           = memWdata_q;
  assign memLock            = memLock_q;
  assign memUncachedAccessN = memUncN_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_segOk;
    state_q == ST_SEG && memAck && !memErr && eV;
  endsequence
  sequence s_pteOk;
    state_q == ST_PTE && memAck && !memErr && eV && !deny(eU, eW);
  endsequence

  a_seg_addr: assert property (state_q == ST_LOOK && !fHit && !tlbUse |=> // R1
    memReq_q && !memLock_q && memAddr_q == {root_q[31:12], va_q[31:22], 2'b00} && memUncN_q)
    else $error("segment entry address wrong");
  a_pte_addr: assert property (s_segOk ##0 !eK |=> memUncN_q == $past(eC) && // R9 R3
    memReq_q && memLock_q && memAddr_q == {$past(memRdata[31:12]), va_q[21:12], 2'b00})
    else $error("page entry address or lock wrong");
  a_flat_pa: assert property (s_segOk ##0 eK && !sOob && !deny(eU, eW) |=> // R6
    rspValid_q && !rspFault_q && rspAddr_q == {$past(memRdata[31:22]), va_q[21:0]})
    else $error("nonpaged physical address wrong");
  a_flat_bound: assert property (s_segOk ##0 eK && sOob |=> rspValid_q && rspFault_q) // R24
    else $error("out of bound access not faulted");
  a_wb_locked: assert property (s_pteOk ##0 (!eR || (write_q && !eM)) |=> // R19
    (memLock_q && memWrite_q) throughout (memReq_q [*1] ##1 state_q == ST_WB))
    else $error("write-back without lock");
  a_lock_drop: assert property (state_q == ST_WB && memAck |=> !memLock_q && !memReq_q) // R19
    else $error("lock not released after write-back");
  a_bus_err: assert property ((state_q == ST_SEG || state_q == ST_PTE || state_q == ST_WB)
    && memAck && memErr |=> rspValid_q && rspKind_q == sptw_pkg::FLT_BUS && !memReq_q) // R20
    else $error("bus error not turned into exception");
  a_tlb_once: assert property (state_q == ST_LOOK && tlbUse |=> rspValid_q ##1 !rspValid_q) // R23
    else $error("buffer hit not answered in one cycle");
  a_phys_mode: assert property (state_q == ST_IDLE && reqValid && reqReady_q && !translateOn
    |=> rspValid_q && rspAddr_q == $past(reqAddr) && !rspFault_q) // R21
    else $error("physical mode request translated");
  a_fault_kind: assert property (rspValid_q && rspFault_q |-> rspKind_q != sptw_pkg::FLT_NONE
    && $past(state_q) != ST_WB || rspKind_q == sptw_pkg::FLT_BUS) // R22
    else $error("fault without kind");
endmodule // sptw_walker
`default_nettype wire

//--- dv/sptw_mem_model.sv
// word memory holding the translation tables, acks after lat idle cycles
// assumes memReq is held until acked, one access at a time
`timescale 1ns/1ps
`default_nettype none
module sptw_mem_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  input  wire logic        memWrite,
  input  wire logic [31:0] memWdata,
  input  wire logic [31:0] errAddr,
  input  wire logic [1:0]  lat,
  output logic             memAck,
  output logic             memErr,
  output logic [31:0]      memRdata
);
  logic [31:0] mem [logic [31:0]];
  int          waitCnt = 0;
  initial memRdata = 32'h5a5a_a5a5;
  // data lines scramble outside an answer so stale reads show
  always @(posedge clk) begin
    memAck <= 1'b0;
    memErr <= 1'b0;
    memRdata <= ~memRdata;
    if (!resetn) waitCnt <= 0;
    else if (memReq && !memAck) begin
      if (waitCnt >= lat) begin
        memAck <= 1'b1;
        waitCnt <= 0;
        memErr <= (memAddr == errAddr);
        if (memWrite) mem[memAddr] = memWdata;
        else memRdata <= mem.exists(memAddr) ? mem[memAddr] : 32'h0;
      end else waitCnt <= waitCnt + 1;
    end
  end
endmodule // sptw_mem_model
`default_nettype wire

//--- dv/sptw_walker_tb.sv
// random translations checked against a table walk reference
// assumes sptw_mem_model answers the walker's memory side
`timescale 1ns/1ps
`default_nettype none
module sptw_walker_tb;
  logic clk = 1'b0, resetn = 1'b0, translateOn = 1'b1, rootWrite = 1'b0;
  logic dropTranslationOp = 1'b0, reqValid = 1'b0, reqText = 1'b0, reqWrite = 1'b0;
  logic reqUser = 1'b0, reqReady, rspValid, rspUncachedAccessN, rspFault;
  logic memReq, memWrite, memLock, memUncachedAccessN, memAck, memErr;
  logic [31:0] tableRootPointer = 32'h0, dropAddr = 32'h0, reqAddr = 32'h0, rspAddr;
  logic [31:0] memAddr, memWdata, memRdata, errAddr = 32'hffff_fffc, root;
  logic [1:0]  lat = 2'h0;
  logic [31:0] refMem [logic [31:0]];
  sptw_pkg::sptw_fault_e rspFaultKind;
  int n_mismatch = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  sptw_walker dut_u (.clk, .resetn, .translateOn, .tableRootPointer, .rootWrite,
    .dropTranslationOp, .dropAddr, .reqValid, .reqAddr, .reqText, .reqWrite, .reqUser,
    .reqReady, .rspValid, .rspAddr, .rspUncachedAccessN, .rspFault, .rspFaultKind,
    .memReq, .memAddr, .memWrite, .memWdata, .memLock, .memUncachedAccessN, .memAck,
    .memErr, .memRdata);
  sptw_mem_model mem_u (.clk, .resetn, .memReq, .memAddr, .memWrite, .memWdata,
    .errAddr, .lat, .memAck, .memErr, .memRdata);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    refMem[a] = d;
    mem_u.mem[a] = d;
  endtask
  task automatic setRoot(input logic [31:0] r);
    @(posedge clk);
    root = r;
    tableRootPointer <= r;
    rootWrite <= 1'b1;
    @(posedge clk);
    rootWrite <= 1'b0;
  endtask
  // reference walk from the bench's own copy of the tables, then one request
  task automatic req(input logic [31:0] va, input logic t, w, u);
    logic [31:0] se, pe, ea, pa;
    logic [2:0]  fk, bad;
    logic        nc;
    int          n;
    @(posedge clk);
    pa = va;
    fk = 3'h0;
    nc = 1'b1;
    bad = w ? 3'h3 : (t ? 3'h1 : 3'h2);
    ea = {root[31:12], va[31:22], 2'b00};
    se = refMem.exists(ea) ? refMem[ea] : 32'h0;
    if (!translateOn) fk = 3'h0;
    else if (ea == errAddr) fk = 3'h4;
    else if (!se[0]) fk = bad;
    else if (se[3]) begin
      if (va[21:12] > se[21:12] || (u && !se[2]) || (w && !se[1])) fk = bad;
      pa = {se[31:22], va[21:0]};
      nc = se[11];
    end else begin
      ea = {se[31:12], va[21:12], 2'b00};
      pe = refMem.exists(ea) ? refMem[ea] : 32'h0;
      if (ea == errAddr) fk = 3'h4;
      else if (!pe[0] || (u && !pe[2]) || (w && !pe[1])) fk = bad;
      else refMem[ea] = pe | 32'h8 | (w ? 32'h10 : 32'h0);
      pa = {pe[31:12], va[11:0]};
      nc = pe[11];
    end
    if (fk != 3'h0) pa = va;
    reqValid <= 1'b1;
    reqAddr <= va;
    reqText <= t;
    reqWrite <= w;
    reqUser <= u;
    n = 0;
    do begin @(posedge clk); n++; end while (reqReady !== 1'b1 && n < 300);
    reqValid <= 1'b0;
    do begin @(posedge clk); n++; end while (rspValid !== 1'b1 && n < 300);
    chk(n < 300, 1'b1);
    chk(rspAddr, pa);
    chk(rspFault, fk != 3'h0);
    chk(rspFaultKind, fk);
    if (translateOn && fk == 3'h0) chk(rspUncachedAccessN, nc);
    if (translateOn) chk(mem_u.mem[ea], refMem[ea]);
  endtask
  initial begin
    logic [31:0] va;
    logic        w;
    void'($urandom(29));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    setRoot(32'h0001_0000);
    put(32'h0001_0000, 32'h0002_0801);
    put(32'h0001_0004, 32'h4000_380f);
    put(32'h0001_0008, 32'h803f_f009);
    put(32'h0001_000c, 32'h0);
    put(32'h0003_0000, 32'h5540_080f);
    put(32'h0003_0004, 32'h0002_0001);
    for (int p = 0; p < 8; p++) put(32'h0002_0000 + p * 4, ($urandom() & 32'hffff_f806) | (p < 6));
    // mixed kinds, rights and page indices past the bound
    for (int i = 0; i < 80; i++) begin
      va = {8'h0, 2'($urandom()), 7'h0, 3'($urandom()), 12'($urandom())};
      w = 1'($urandom());
      lat <= 2'($urandom());
      req(va, !w && 1'($urandom()), w, 1'($urandom()));
    end
    req(32'h0000_0abc, 1'b0, 1'b0, 1'b0);
    setRoot(32'h0003_0000);
    req(32'h0000_0abc, 1'b0, 1'b0, 1'b0);
    // paged segment marked uncached: page entry read goes out uncached
    req(32'h0040_0abc, 1'b0, 1'b0, 1'b0);
    setRoot(32'h0001_0000);
    errAddr <= 32'h0002_0008;
    req(32'h0000_2000, 1'b0, 1'b0, 1'b0);
    errAddr <= 32'hffff_fffc;
    req(32'h0000_2000, 1'b0, 1'b1, 1'b0);
    req(32'h0000_1010, 1'b0, 1'b0, 1'b0);
    put(32'h0002_0004, 32'h0abc_d807);
    @(posedge clk);
    dropTranslationOp <= 1'b1;
    dropAddr <= 32'h0000_1010;
    @(posedge clk);
    dropTranslationOp <= 1'b0;
    req(32'h0000_1010, 1'b0, 1'b0, 1'b1);
    // stale flat entry must not survive a mid-run reset; root resets to zero
    setRoot(32'h0000_0000);
    put(32'h0000_0000, 32'h4000_380f);
    req(32'h0000_0abc, 1'b0, 1'b0, 1'b0);
    put(32'h0000_0000, 32'h5540_080f);
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    req(32'h0000_0abc, 1'b0, 1'b0, 1'b0);
    translateOn <= 1'b0;
    req(32'h1234_5678, 1'b0, 1'b1, 1'b1);
    give_verdict();
  end
  // cut a hang short well past the expected run length
  initial begin
    #100us;
    n_mismatch++;
    give_verdict();
  end
endmodule // sptw_walker_tb
`default_nettype wire
